// *** fcs_defines.svh ***
// constants of the flash command sequencer: commands, offsets, bits, timing
`ifndef FCS_DEFINES_SVH
`define FCS_DEFINES_SVH
// ----------------------------------------
// command bytes
// ----------------------------------------
`define FCS_CMD_READ  8'hFF
`define FCS_CMD_STAT  8'h70
`define FCS_CMD_CLR   8'h50
`define FCS_CMD_PROG  8'h40
`define FCS_CMD_ERASE 8'h20
`define FCS_CMD_CONF  8'hD0
// ----------------------------------------
// address map
// ----------------------------------------
`define FCS_REG_SEL   15
`define FCS_OFF_CTRL  16'h8000
`define FCS_OFF_PROT  16'h8004
`define FCS_OFF_SUSP  16'h8008
`define FCS_BLK_HI    12
`define FCS_BLK_LO    11
`define FCS_BLK_NONE  2'h3
// ----------------------------------------
// bit positions
// ----------------------------------------
`define FCS_SR_PER    4
`define FCS_SR_EER    5
`define FCS_SR_RDY    7
`define FCS_CT_RDY    0
`define FCS_CT_CRE    1
`define FCS_CT_LBE    2
`define FCS_CT_PER    6
`define FCS_CT_EER    7
`define FCS_PR_EW1    1
`define FCS_PR_B0D    5
`define FCS_PR_B1D    6
`define FCS_PR_ONE    7
`define FCS_SU_SEN    0
`define FCS_SU_ESR    1
`define FCS_SU_PSR    2
`define FCS_SU_EACT   3
`define FCS_SU_PACT   4
`define FCS_SU_RDOK   6
`define FCS_SU_LPR    7
// ----------------------------------------
// timing
// ----------------------------------------
`define FCS_CLK_MHZ   20
`define FCS_PROG_US   50
`define FCS_ERASE_US  100
`define FCS_PROG_CYC  (`FCS_PROG_US * `FCS_CLK_MHZ)
`define FCS_ERASE_CYC (`FCS_ERASE_US * `FCS_CLK_MHZ)
`endif

// *** fcs_pkg.sv ***
// types of the flash command sequencer
package fcs_pkg;
  typedef logic [7:0] fcs_byte_t;
  typedef enum logic [1:0] {FM_ARRAY, FM_STATUS, FM_PROG_WAIT,
                            FM_ERASE_WAIT} fcs_mode_e;
  typedef enum logic [1:0] {EN_IDLE, EN_RUN, EN_HOLD} fcs_eng_e;
  typedef struct packed {
    logic cre;
    logic lbe;
    logic ew1;
    logic b0d;
    logic b1d;
    logic sen;
    logic lpr;
    logic perr;
    logic eerr;
    logic esr;
    logic psr;
    logic eact;
    logic pact;
  } fcs_regs_s;
endpackage

// *** fcs_ifs.sv ***
// carriers between the sequencer core, its bus slave and its engine
`timescale 1ns/1ps
interface fcs_bus_if;
  logic        look;
  logic        act;
  logic        wen;
  logic [15:0] addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  modport wbs  (output look, act, wen, addr, wdata, input rdata);
  modport core (input look, act, wen, addr, wdata, output rdata);
endinterface

interface fcs_op_if;
  logic start;
  logic erase;
  logic hold;
  logic vfail;
  logic busy;
  logic run;
  logic done;
  logic fail;
  modport eng  (input start, erase, hold, vfail,
                output busy, run, done, fail);
  modport core (output start, erase, hold, vfail,
                input busy, run, done, fail);
endinterface

// *** fcs_wbs.sv ***
// classic wishbone slave: two wait states, byte lane 0 only
`timescale 1ns/1ps
module fcs_wbs (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [15:0] wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic             wb_ack_o,
  output logic [31:0]      wb_dat_o,
  fcs_bus_if.wbs           b
);
  logic        req;
  logic        ph_q, ph_d, ack_q, ack_d;
  logic [31:0] dat_q, dat_d;

  // first cycle sets the array address, second answers
  always_comb begin
    req   = wb_cyc_i & wb_stb_i & ~ack_q;
    ph_d  = req & ~ph_q;
    ack_d = req & ph_q;
    dat_d = ack_d ? {24'h000000, b.rdata} : dat_q;
  end

  assign b.look  = req & ~ph_q;
  assign b.act   = ack_d;
  assign b.wen   = wb_we_i & wb_sel_i[0];
  assign b.addr  = wb_adr_i;
  assign b.wdata = wb_dat_i[7:0];
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  always_ff @(posedge mclk) begin
    if (rst) begin
      ph_q  <= 1'b0;
      ack_q <= 1'b0;
      dat_q <= 32'h00000000;
    end else begin
      ph_q  <= ph_d;
      ack_q <= ack_d;
      dat_q <= dat_d;
    end
  end
endmodule

// *** fcs_engine.sv ***
// auto program / auto erase timing engine with suspend hold
`timescale 1ns/1ps
`include "fcs_defines.svh"
module fcs_engine
  import fcs_pkg::*;
(
  input  wire logic mclk,
  input  wire logic rst,
  fcs_op_if.eng     op
);
  fcs_eng_e    st_q, st_d;
  logic [11:0] cnt_q, cnt_d;
  logic        done_q, done_d, fail_q, fail_d;

  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    done_d = 1'b0;
    fail_d = 1'b0;
    case (st_q)
      EN_IDLE: if (op.start) begin
        st_d  = EN_RUN;
        cnt_d = op.erase ? 12'(`FCS_ERASE_CYC - 1)
                         : 12'(`FCS_PROG_CYC - 1);
      end
      // verify result is only sampled at the last step
      EN_RUN: if (op.hold) begin
        st_d = EN_HOLD;
      end else if (cnt_q == 12'h000) begin
        st_d   = EN_IDLE;
        done_d = 1'b1;
        fail_d = op.vfail;
      end else begin
        cnt_d = cnt_q - 12'h001;
      end
      EN_HOLD: if (!op.hold) begin
        st_d = EN_RUN;
      end
      default: st_d = EN_IDLE;
    endcase
  end

  assign op.busy = (st_q != EN_IDLE);
  assign op.run  = (st_q == EN_RUN);
  assign op.done = done_q;
  assign op.fail = fail_q;

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_q   <= EN_IDLE;
      cnt_q  <= 12'h000;
      done_q <= 1'b0;
      fail_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      done_q <= done_d;
      fail_q <= fail_d;
    end
  end
endmodule

// *** fcs_top.sv ***
// flash command sequencer: command decode, status, protection, suspend
//
// What this block does, and what software must do
// R1: writing FFh as a command enters array-read mode.
// R2: reset leaves array-read mode, kept until another command.
// R3: writing 70h makes flash reads return the status byte until FFh.
// R4: writing 50h clears both error flags in status and control register.
// R5: 40h then a data byte starts auto program at that address.
// R6: 20h then D0h inside a block starts auto erase of that block.
// R7: status ready bit D7 is 0 during an operation, 1 on completion.
// R8: program-active flag is 1 during auto program, 0 when it ends.
// R9: in RAM-executed mode starting an operation enters status-read mode.
// R10: block 0 locked by low enable or its disable; block 1 by its disable.
// R11: no program or erase is accepted while an error flag is set.
// R12: status byte has program error D4, erase error D5, ready D7.
// R13: erase suspend request works only during an erase with suspend on.
// R14: flash-executed mode: interrupt during erase sets erase suspend request.
// R15: program suspend request writable only during a program, suspend on.
// R16: flash-executed mode: interrupt during program sets its request; no 1.
// R17: software sets enables by writing 0 then 1 with no interrupt.
// R18: software keeps low-power read off at high speed and when rewriting.
// R19: software gives the same address in both program bus cycles.
// R20: software never programs an address twice without an erase.
// R21: software issues no erase while a program is suspended.
// R22: software issues no status-read command in flash-executed mode.
// R23: erase-active flag rises at erase start, holds in suspend, then clears.
// R24: read-allowed flag is 0 while running, 1 while suspended.
// R25: a malformed sequence or locked target sets both error flags.
// R26: reserved status bits D0 to D3 and D6 read as zero.
//
// The register addresses and the Wishbone slave port are this design's own decisions.
`timescale 1ns/1ps
`include "fcs_defines.svh"
module fcs_top
  import fcs_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [15:0] wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic             wb_ack_o,
  output logic [31:0]      wb_dat_o,
  input  wire logic        irq_req,
  input  wire logic        arr_verify_fail,
  input  wire logic [7:0]  arr_rdata,
  output logic [12:0]      arr_addr,
  output logic [7:0]       arr_wdata,
  output logic             arr_prog,
  output logic             arr_erase
);
  // ----------------------------------------
  // sub blocks
  // ----------------------------------------
  fcs_bus_if bus ();
  fcs_op_if  op ();

  fcs_wbs u_wbs (
    .mclk     (mclk),
    .rst      (rst),
    .wb_cyc_i (wb_cyc_i),
    .wb_stb_i (wb_stb_i),
    .wb_we_i  (wb_we_i),
    .wb_adr_i (wb_adr_i),
    .wb_dat_i (wb_dat_i),
    .wb_sel_i (wb_sel_i),
    .wb_ack_o (wb_ack_o),
    .wb_dat_o (wb_dat_o),
    .b        (bus.wbs)
  );

  fcs_engine u_eng (
    .mclk (mclk),
    .rst  (rst),
    .op   (op.eng)
  );

  // ----------------------------------------
  // state
  // ----------------------------------------
  fcs_mode_e   mode_q, mode_d;
  fcs_regs_s   r_q, r_d;
  logic [12:0] tgt_q, tgt_d, addr_q, addr_d, idx;
  fcs_byte_t   wdat_q, wdat_d, wd, sb, rd;
  logic        prog_q, prog_d, erase_q, erase_d;
  logic        fl, cw, busy, errs, start, sera;
  logic [1:0]  blk;

  // unallocated block counts as locked
  function automatic logic locked(input logic [1:0] b,
                                  input fcs_regs_s r);
    return (b == 2'h0 && (!r.lbe || r.b0d)) ||
           (b == 2'h1 && r.b1d) || (b == `FCS_BLK_NONE);
  endfunction

  assign fl   = !bus.addr[`FCS_REG_SEL];
  assign idx  = bus.addr[14:2];
  assign blk  = idx[`FCS_BLK_HI:`FCS_BLK_LO];
  assign wd   = bus.wdata;
  assign busy = op.busy;
  assign errs = r_q.perr | r_q.eerr;
  assign cw   = bus.act & bus.wen & fl & r_q.cre;

  // ----------------------------------------
  // command decode and registers
  // ----------------------------------------
  always_comb begin
    mode_d  = mode_q;
    r_d     = r_q;
    tgt_d   = tgt_q;
    addr_d  = addr_q;
    wdat_d  = wdat_q;
    prog_d  = 1'b0;
    erase_d = 1'b0;
    start   = 1'b0;
    sera    = 1'b0;
    if (op.done) begin
      r_d.eact = 1'b0;                                  // [R23]
      r_d.pact = 1'b0;                                  // [R8]
    end
    if (bus.look) begin
      addr_d = idx;
    end
    if (cw) begin
      case (mode_q)
        FM_PROG_WAIT: begin
          mode_d = FM_STATUS;
          if (errs || busy) begin
            mode_d = FM_STATUS;                         // [R11]
          end else if (locked(blk, r_q)) begin
            r_d.perr = 1'b1;                            // [R10] [R25]
            r_d.eerr = 1'b1;
          end else begin
            start    = 1'b1;                            // [R5]
            prog_d   = 1'b1;
            wdat_d   = wd;
            addr_d   = tgt_q;
            r_d.pact = 1'b1;                            // [R8]
            if (r_q.ew1) begin
              mode_d = FM_ARRAY;
            end
          end
        end
        FM_ERASE_WAIT: begin
          mode_d = FM_STATUS;
          if (wd == `FCS_CMD_READ) begin
            mode_d = FM_ARRAY;
          end else if (wd != `FCS_CMD_CONF) begin
            r_d.perr = 1'b1;                            // [R25]
            r_d.eerr = 1'b1;
          end else if (errs || busy) begin
            mode_d = FM_STATUS;                         // [R11]
          end else if (locked(blk, r_q)) begin
            r_d.perr = 1'b1;                            // [R10] [R25]
            r_d.eerr = 1'b1;
          end else begin
            start    = 1'b1;                            // [R6]
            sera     = 1'b1;
            erase_d  = 1'b1;
            addr_d   = idx;
            r_d.eact = 1'b1;                            // [R23]
            if (r_q.ew1) begin
              mode_d = FM_ARRAY;                        // [R9]
            end
          end
        end
        default: case (wd)
          `FCS_CMD_READ:  mode_d = FM_ARRAY;            // [R1]
          `FCS_CMD_STAT:  mode_d = FM_STATUS;           // [R3]
          `FCS_CMD_CLR: begin
            r_d.perr = 1'b0;                            // [R4]
            r_d.eerr = 1'b0;
          end
          `FCS_CMD_PROG: begin
            mode_d = FM_PROG_WAIT;
            tgt_d  = idx;
          end
          `FCS_CMD_ERASE: mode_d = FM_ERASE_WAIT;
          default: begin
            mode_d   = FM_STATUS;
            r_d.perr = 1'b1;                            // [R25]
            r_d.eerr = 1'b1;
          end
        endcase
      endcase
    end
    // failure set wins over a clear in the same cycle
    if (op.done && op.fail) begin
      if (r_q.eact) begin
        r_d.eerr = 1'b1;
      end else begin
        r_d.perr = 1'b1;
      end
    end
    if (bus.act && bus.wen && !fl) begin
      case (bus.addr)
        `FCS_OFF_CTRL: begin
          r_d.cre = wd[`FCS_CT_CRE];
          r_d.lbe = wd[`FCS_CT_CRE] & wd[`FCS_CT_LBE];
          if (!wd[`FCS_CT_CRE]) begin
            r_d.ew1 = 1'b0;
            r_d.b0d = 1'b0;
            r_d.b1d = 1'b0;
          end
        end
        `FCS_OFF_PROT: begin
          r_d.ew1 = wd[`FCS_PR_EW1];
          if (r_q.cre) begin
            r_d.b0d = wd[`FCS_PR_B0D];
            r_d.b1d = wd[`FCS_PR_B1D];
          end
        end
        `FCS_OFF_SUSP: begin
          r_d.sen = wd[`FCS_SU_SEN];
          r_d.lpr = wd[`FCS_SU_LPR];
          if (!r_q.ew1 || !wd[`FCS_SU_ESR]) begin
            r_d.esr = wd[`FCS_SU_ESR];                  // [R13] [R14]
          end
          if (!r_q.ew1 || !wd[`FCS_SU_PSR]) begin
            r_d.psr = wd[`FCS_SU_PSR];                  // [R15] [R16]
          end
        end
        default: r_d.sen = r_q.sen;
      endcase
    end
    // interrupt suspend beats a software clear
    if (r_q.ew1 && r_q.sen && irq_req && op.run) begin
      if (r_q.eact) begin
        r_d.esr = 1'b1;                                 // [R14]
      end
      if (r_q.pact) begin
        r_d.psr = 1'b1;                                 // [R16]
      end
    end
    if (!r_d.sen || !r_d.eact) begin
      r_d.esr = 1'b0;                                   // [R13]
    end
    if (!r_d.sen || !r_d.pact) begin
      r_d.psr = 1'b0;                                   // [R15]
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      mode_q  <= FM_ARRAY;                              // [R2]
      r_q     <= '0;
      tgt_q   <= 13'h0000;
      addr_q  <= 13'h0000;
      wdat_q  <= 8'h00;
      prog_q  <= 1'b0;
      erase_q <= 1'b0;
    end else begin
      mode_q  <= mode_d;
      r_q     <= r_d;
      tgt_q   <= tgt_d;
      addr_q  <= addr_d;
      wdat_q  <= wdat_d;
      prog_q  <= prog_d;
      erase_q <= erase_d;
    end
  end

  assign op.start   = start;
  assign op.erase   = sera;
  assign op.hold    = r_q.esr | r_q.psr;
  assign op.vfail   = arr_verify_fail;
  assign arr_addr   = addr_q;
  assign arr_wdata  = wdat_q;
  assign arr_prog   = prog_q;
  assign arr_erase  = erase_q;

  // ----------------------------------------
  // read data
  // ----------------------------------------
  always_comb begin
    sb = 8'h00;                                         // [R26]
    sb[`FCS_SR_RDY] = !busy;                            // [R7] [R12]
    sb[`FCS_SR_PER] = r_q.perr;                         // [R12]
    sb[`FCS_SR_EER] = r_q.eerr;
    rd = 8'h00;
    if (fl) begin
      rd = (mode_q == FM_STATUS) ? sb : arr_rdata;      // [R3] [R9]
    end else begin
      case (bus.addr)
        `FCS_OFF_CTRL: begin
          rd[`FCS_CT_RDY] = !busy;                      // [R12]
          rd[`FCS_CT_CRE] = r_q.cre;
          rd[`FCS_CT_LBE] = r_q.lbe;
          rd[`FCS_CT_PER] = r_q.perr;
          rd[`FCS_CT_EER] = r_q.eerr;
        end
        `FCS_OFF_PROT: begin
          rd[`FCS_PR_EW1] = r_q.ew1;
          rd[`FCS_PR_B0D] = r_q.b0d;
          rd[`FCS_PR_B1D] = r_q.b1d;
          rd[`FCS_PR_ONE] = 1'b1;
        end
        `FCS_OFF_SUSP: begin
          rd[`FCS_SU_SEN]  = r_q.sen;
          rd[`FCS_SU_ESR]  = r_q.esr;
          rd[`FCS_SU_PSR]  = r_q.psr;
          rd[`FCS_SU_EACT] = r_q.eact;                  // [R23]
          rd[`FCS_SU_PACT] = r_q.pact;                  // [R8]
          rd[`FCS_SU_RDOK] = !op.run;                   // [R24]
          rd[`FCS_SU_LPR]  = r_q.lpr;
        end
        default: rd = 8'h00;
      endcase
    end
  end
  assign bus.rdata = rd;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  AST_CLEAR: assert property (cw && wd == `FCS_CMD_CLR && !op.done && // [R4]
      mode_q != FM_PROG_WAIT && mode_q != FM_ERASE_WAIT
      |=> !sb[`FCS_SR_PER] && !sb[`FCS_SR_EER])
    else $error("clear status left an error flag");
  AST_BUSY: assert property (start |=> !sb[`FCS_SR_RDY] ##1 // [R7]
      !sb[`FCS_SR_RDY])
    else $error("ready not low after start");
  AST_DONE: assert property (op.done |-> sb[`FCS_SR_RDY]) // [R7]
    else $error("ready not high at completion");
  AST_PACT: assert property ($rose(r_q.pact) |-> $past(start) && // [R8]
      !$past(sera))
    else $error("program flag rose without program start");
  AST_EW0: assert property (start && !r_q.ew1 |=> // [R9]
      mode_q == FM_STATUS)
    else $error("no status mode after start");
  AST_LOCK: assert property (cw && mode_q == FM_PROG_WAIT && !errs && // [R10]
      !busy && blk == 2'h0 && (!r_q.lbe || r_q.b0d)
      |=> !busy && r_q.perr && r_q.eerr)
    else $error("locked block was programmed");
  AST_ERRS: assert property (errs |-> !start) // [R11]
    else $error("operation started with error set");
  AST_ESR: assert property (r_q.esr |-> r_q.sen && r_q.eact) // [R13]
    else $error("erase suspend request outside erase");
  AST_IRQ: assert property (r_q.ew1 && r_q.sen && r_q.eact && // [R14]
      irq_req && op.run && !op.done |=> r_q.esr)
    else $error("interrupt did not request erase suspend");
  AST_RDOK: assert property (bus.act && !bus.wen && !fl && // [R24]
      bus.addr == `FCS_OFF_SUSP |=> wb_dat_o[`FCS_SU_RDOK] != $past(op.run))
    else $error("read allowed while running");

  COV_PROG:  cover property (start && !sera);
  COV_ERASE: cover property (start && sera);
  COV_SUSP:  cover property ($rose(r_q.esr));
endmodule

// *** fcs_flash_model.sv ***
// flash array model behind the sequencer core
`timescale 1ns/1ps
module fcs_flash_model (
  input  wire logic        mclk,
  input  wire logic [12:0] arr_addr,
  input  wire logic [7:0]  arr_wdata,
  input  wire logic        arr_prog,
  input  wire logic        arr_erase,
  input  wire logic        fail_en,
  output logic             arr_verify_fail,
  output logic [7:0]       arr_rdata
);
  logic [7:0] mem [8192];

  initial begin
    for (int i = 0; i < 8192; i++) begin
      mem[i] = 8'hFF;
    end
  end

  // programming only clears bits, so a second program shows up as damage
  always @(posedge mclk) begin
    if (arr_prog) begin
      mem[arr_addr] <= mem[arr_addr] & arr_wdata;
    end
    if (arr_erase) begin
      for (int i = 0; i < 2048; i++) begin
        mem[{arr_addr[12:11], i[10:0]}] <= 8'hFF;
      end
    end
  end

  assign arr_rdata       = mem[arr_addr];
  assign arr_verify_fail = fail_en;
endmodule

// *** flash_command_sequencer_test.sv ***
// self-checking bench of the flash command sequencer
`timescale 1ns/1ps
`include "fcs_defines.svh"
module flash_command_sequencer_test;
  logic        mclk    = 1'b0;
  logic        rst     = 1'b1;
  logic        wb_cyc  = 1'b0;
  logic        wb_stb  = 1'b0;
  logic        wb_we   = 1'b0;
  logic [15:0] wb_adr  = 16'h0000;
  logic [31:0] wb_dat  = 32'h0000_0000;
  logic [3:0]  wb_sel  = 4'h0;
  logic        wb_ack;
  logic [31:0] wb_rdat;
  logic        irq_req = 1'b0;
  logic        vfail   = 1'b0;
  logic        arr_vf;
  logic [7:0]  arr_rdata;
  logic [12:0] arr_addr;
  logic [7:0]  arr_wdata;
  logic        arr_prog;
  logic        arr_erase;
  int          n_fail  = 0;
  int          checks  = 0;
  int          cycles  = 0;
  logic [31:0] seed    = 32'h0000_8A86;

  localparam logic [7:0]  PROT_T [4] = '{8'h80, 8'hA0, 8'hC0, 8'h80};
  localparam logic [12:0] IDX_T  [4] = '{13'h0010, 13'h0010, 13'h0810,
                                         13'h1810};

  fcs_top u_dut (
    .mclk            (mclk),
    .rst             (rst),
    .wb_cyc_i        (wb_cyc),
    .wb_stb_i        (wb_stb),
    .wb_we_i         (wb_we),
    .wb_adr_i        (wb_adr),
    .wb_dat_i        (wb_dat),
    .wb_sel_i        (wb_sel),
    .wb_ack_o        (wb_ack),
    .wb_dat_o        (wb_rdat),
    .irq_req         (irq_req),
    .arr_verify_fail (arr_vf),
    .arr_rdata       (arr_rdata),
    .arr_addr        (arr_addr),
    .arr_wdata       (arr_wdata),
    .arr_prog        (arr_prog),
    .arr_erase       (arr_erase)
  );

  fcs_flash_model u_flash (
    .mclk            (mclk),
    .arr_addr        (arr_addr),
    .arr_wdata       (arr_wdata),
    .arr_prog        (arr_prog),
    .arr_erase       (arr_erase),
    .fail_en         (vfail),
    .arr_verify_fail (arr_vf),
    .arr_rdata       (arr_rdata)
  );

  always #25 mclk = ~mclk;

  // ----------------------------------------
  // expectations
  // ----------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  function automatic logic [15:0] fa(input logic [12:0] i);
    return {1'h0, i, 2'h0};
  endfunction

  // rewrite enable assumed on in every use
  function automatic logic [7:0] ctrl_x(input logic lbe, per, eer, rdy);
    return {eer, per, 3'h0, lbe, 1'h1, rdy};
  endfunction

  function automatic logic [7:0] stat_x(input logic rdy, per, eer);
    return {rdy, 1'h0, eer, per, 4'h0};
  endfunction

  function automatic logic [7:0] susp_x(input logic sen, esr, psr, eact,
                                        pact, rdok);
    return {1'h0, rdok, 1'h0, pact, eact, psr, esr, sen};
  endfunction

  // ----------------------------------------
  // bus cycles and checks
  // ----------------------------------------
  task automatic chk(input string w, input logic [7:0] e,
                     input logic [7:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", w, e, g);
    end
  endtask

  task automatic bus(input logic we, input logic [15:0] a,
                     input logic [7:0] d, output logic [7:0] r);
    int n;
    n = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= we;
    wb_adr <= a;
    wb_dat <= {24'h0, d};
    wb_sel <= 4'hF;
    do begin
      @(posedge mclk);
      n++;
    end while (wb_ack !== 1'b1 && n < 16);
    chk("ack", 8'h01, {7'h0, wb_ack});
    r = wb_rdat[7:0];
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    logic [7:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rd(input string w, input logic [15:0] a,
                    input logic [7:0] e);
    logic [7:0] r;
    bus(1'b0, a, 8'h00, r);
    chk(w, e, r);
  endtask

  // polling bounded; a lost done ends the wait and is caught by the checks after it
  task automatic wait_rdy;
    logic [7:0] r;
    int n;
    n = 0;
    r = 8'h00;
    while (r[`FCS_CT_RDY] !== 1'b1 && n < 1000) begin
      bus(1'b0, `FCS_OFF_CTRL, 8'h00, r);
      n++;
    end
  endtask

  task automatic prog(input logic [12:0] i, input logic [7:0] d);
    wr(fa(i), `FCS_CMD_PROG);
    wr(fa(i), d);  // same address in both cycles
  endtask

  task automatic end_of_test;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 40000) begin
      n_fail++;
      end_of_test();
    end
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    logic [12:0] idx;
    logic [7:0]  dat;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    rd("ctrl rst", `FCS_OFF_CTRL, 8'h01);
    rd("prot rst", `FCS_OFF_PROT, 8'h80);
    rd("susp rst", `FCS_OFF_SUSP, susp_x(0, 0, 0, 0, 0, 1));
    rd("unmapped", 16'h800C, 8'h00);
    wr(`FCS_OFF_SUSP, 8'h06);  // low power stays off
    rd("susp idle", `FCS_OFF_SUSP, susp_x(0, 0, 0, 0, 0, 1));
    for (int k = 0; k < 4; k++) begin
      wr(`FCS_OFF_CTRL, 8'h02);  // zero then one
      if (k > 0) wr(`FCS_OFF_CTRL, 8'h06);
      wr(`FCS_OFF_PROT, PROT_T[k]);
      prog(IDX_T[k], 8'h00);
      rd("locked", `FCS_OFF_CTRL, ctrl_x(k > 0, 1, 1, 1));
      if (k == 3) begin
        wr(fa(0), `FCS_CMD_STAT);
        rd("stat err", fa(0), stat_x(1, 1, 1));
      end
      wr(fa(0), `FCS_CMD_CLR);
      rd("cleared", `FCS_OFF_CTRL, ctrl_x(k > 0, 0, 0, 1));
    end
    wr(`FCS_OFF_PROT, 8'h80);
    // distinct bytes only, never programmed twice
    for (int k = 0; k < 3; k++) begin
      seed = xs(seed);
      idx  = 13'h1000 + {k[6:0], seed[5:0]};
      dat  = seed[15:8];
      prog(idx, dat);
      rd("busy", fa(idx), stat_x(0, 0, 0));
      wait_rdy();
      rd("done", fa(idx), stat_x(1, 0, 0));
      wr(fa(idx), `FCS_CMD_READ);
      rd("data", fa(idx), dat);
      rd("blank", fa(idx + 13'h1), 8'hFF);
    end
    vfail <= 1'b1;
    prog(13'h1400, 8'h5A);
    wait_rdy();
    vfail <= 1'b0;
    rd("vfail", `FCS_OFF_CTRL, ctrl_x(1, 1, 0, 1));
    prog(13'h1401, 8'h00);
    wr(fa(0), `FCS_CMD_READ);
    rd("refused", fa(13'h1401), 8'hFF);
    wr(fa(0), `FCS_CMD_CLR);
    wr(`FCS_OFF_SUSP, 8'h00);  // zero then one
    wr(`FCS_OFF_SUSP, 8'h01);
    // no program is held here
    wr(fa(0), `FCS_CMD_ERASE);
    wr(fa(13'h1234), `FCS_CMD_CONF);
    rd("er run", `FCS_OFF_SUSP, susp_x(1, 0, 0, 1, 0, 0));
    wr(`FCS_OFF_SUSP, 8'h03);
    rd("er held", `FCS_OFF_SUSP, susp_x(1, 1, 0, 1, 0, 1));
    rd("held busy", `FCS_OFF_CTRL, ctrl_x(1, 0, 0, 0));
    wr(`FCS_OFF_SUSP, 8'h01);
    wait_rdy();
    rd("er end", `FCS_OFF_SUSP, susp_x(1, 0, 0, 0, 0, 1));
    wr(fa(0), `FCS_CMD_READ);
    rd("erased", fa(idx), 8'hFF);
    wr(fa(0), `FCS_CMD_ERASE);
    wr(fa(13'h1000), 8'h55);
    rd("bad 2nd", `FCS_OFF_CTRL, ctrl_x(1, 1, 1, 1));
    wr(fa(0), `FCS_CMD_CLR);
    wr(fa(0), `FCS_CMD_STAT);
    rd("stat clr", fa(0), stat_x(1, 0, 0));
    wr(fa(0), `FCS_CMD_READ);
    // no status command from here on
    wr(`FCS_OFF_PROT, 8'h82);
    prog(13'h1500, 8'h3C);
    wr(`FCS_OFF_SUSP, 8'h05);  // software one ignored
    rd("p run", `FCS_OFF_SUSP, susp_x(1, 0, 0, 0, 1, 0));
    irq_req <= 1'b1;
    // request must reach the engine before the read samples the flags
    @(posedge mclk);
    rd("p irq", `FCS_OFF_SUSP, susp_x(1, 0, 1, 0, 1, 1));
    irq_req <= 1'b0;
    wr(`FCS_OFF_SUSP, 8'h01);
    wait_rdy();
    rd("p end", `FCS_OFF_SUSP, susp_x(1, 0, 0, 0, 0, 1));
    rd("ew1 data", fa(13'h1500), 8'h3C);
    wr(fa(0), `FCS_CMD_ERASE);
    wr(fa(13'h1100), `FCS_CMD_CONF);
    irq_req <= 1'b1;
    @(posedge mclk);
    rd("e irq", `FCS_OFF_SUSP, susp_x(1, 1, 0, 1, 0, 1));
    irq_req <= 1'b0;
    wr(`FCS_OFF_SUSP, 8'h01);
    wait_rdy();
    rd("e end", `FCS_OFF_SUSP, susp_x(1, 0, 0, 0, 0, 1));
    wr(`FCS_OFF_CTRL, 8'h00);  // rewrite off before low power
    rd("prot off", `FCS_OFF_PROT, 8'h80);
    wr(`FCS_OFF_SUSP, 8'h00);  // zero then one
    wr(`FCS_OFF_SUSP, 8'h80);
    rd("low power", `FCS_OFF_SUSP, 8'hC0);
    end_of_test();
  end
endmodule
